// ---- rtl/sar_adc_map.vh ----
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH
// Register byte offsets (low address byte)
`define OFS_MODE       8'h00
`define OFS_RES_WIDE   8'h04
`define OFS_RES_HIGH   8'h08
`define OFS_PIN_CFG    8'h0C
`define OFS_CHAN_SEL   8'h10
`define OFS_IRQ_STAT   8'h14
`define OFS_IRQ_MASK   8'h18
`define OFS_MODE_SET   8'h1C
`define OFS_MODE_CLR   8'h20
// converter_mode fields and register reset values
`define MODE_RUN_BIT   7
`define MODE_TSEL_HI   5
`define MODE_TSEL_LO   3
`define MODE_CMP_BIT   0
`define MODE_RESET     8'h00
`define PIN_CFG_RESET  8'h00
`define CHAN_RESET     3'h0
// Conversion clock divisors by conv_time_select
`define DIV_SEL0       8'h0C
`define DIV_SEL1       8'h08
`define DIV_SEL2       8'h06
`define DIV_SEL3       8'h04
`define DIV_SEL4       8'h03
`define DIV_SEL5       8'h02
// Sample and per-bit lengths in conversion clock periods
`define SAMPLE_TICKS   8'h02
`define BIT_TICKS      8'h04
`endif

// ---- rtl/sar_adc_control.v ----
// Notes on behaviour
// - Ten-bit conversions repeat on one selected channel
// - Raise completion interrupt after every conversion
// - Sample at start, hold through conversion
// - Resolve MSB first, copy when LSB decided
// - Wide result: ten upper bits, six zeros
// - High-byte result holds eight MSBs
// - Result reads insert one wait cycle
// - Unselected shared pins stay digital port pins
// - Pin config picks analogue or digital per pin
// - Channel select feeds sample-and-hold input
// - Mode register resets to zero, all stopped
// - Run bit zero stops, one converts continuously
// - Comparator bit enables half-reference comparator
// - Mode register takes bit and byte writes
// - First result after early start is unreliable
// - Wide result split high byte, low byte
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"

module sar_adc_control (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Analogue front end
  input  wire        cmpOut,
  output reg  [9:0]  dacCode,
  output reg         sampleHold,
  output reg  [2:0]  analogueChannel,
  output reg         comparatorOn,
  output reg  [7:0]  analogueInputEn,
  output reg  [7:0]  digitalPortEn,
  // Interrupt
  output reg         convDoneIrq
);

  localparam ST_IDLE    = 3'b001;
  localparam ST_SAMPLE  = 3'b010;
  localparam ST_CONVERT = 3'b100;

  reg  [7:0]  modeQ;
  reg  [7:0]  pinCfgQ;
  reg  [2:0]  chanSelQ;
  reg  [15:0] resultWideQ;
  reg  [7:0]  resultHighQ;
  reg         irqStatQ;
  reg         irqMaskQ;
  reg  [2:0]  stateQ;
  reg  [9:0]  approxQ;
  reg  [9:0]  bitMaskQ;
  reg  [7:0]  phaseCntQ;
  reg         cmpMetaQ;
  reg         cmpSyncQ;
  reg         dataPhaseQ;
  reg         writeQ;
  reg  [7:0]  addrQ;
  reg         waitDoneQ;

  reg  [7:0]  divisor;
  reg  [7:0]  rdValue;
  reg  [9:0]  decided;
  wire        addrPhase = hsel & htrans[1] & hready;
  wire        convRun   = modeQ[`MODE_RUN_BIT];
  wire [2:0]  timeSel   = modeQ[`MODE_TSEL_HI:`MODE_TSEL_LO];
  wire        wrNow     = dataPhaseQ & writeQ & ~waitDoneQ;
  // Products are formed at full width, then cut to the counter width on purpose
  wire [15:0] sampleProd = divisor * `SAMPLE_TICKS;
  wire [15:0] bitProd    = divisor * `BIT_TICKS;
  wire [7:0]  sampleLen  = sampleProd[7:0];
  wire [7:0]  bitLen     = bitProd[7:0];
  wire        phaseEnd  = (phaseCntQ == 8'h01);
  wire        lastBit   = (stateQ == ST_CONVERT) & phaseEnd & bitMaskQ[0];
  wire        doneEvent = lastBit & convRun;
  wire        irqClear  = wrNow & (addrQ == `OFS_IRQ_STAT) & hwdata[0];
  wire        irqNext   = doneEvent | (irqStatQ & ~irqClear);

  always @* begin
    case (timeSel)
      3'h0: divisor = `DIV_SEL0;
      3'h1: divisor = `DIV_SEL1;
      3'h2: divisor = `DIV_SEL2;
      3'h3: divisor = `DIV_SEL3;
      3'h4: divisor = `DIV_SEL4;
      3'h5: divisor = `DIV_SEL5;
      default: divisor = `DIV_SEL0;
    endcase
  end

  // Keep bit when input is at or above the trial level
  always @* begin
    if (cmpSyncQ) begin
      decided = approxQ;
    end else begin
      decided = approxQ & ~bitMaskQ;
    end
  end

  always @* begin
    if (haddr[7:0] == `OFS_MODE) begin
      rdValue = modeQ;
    end else if (haddr[7:0] == `OFS_PIN_CFG) begin
      rdValue = pinCfgQ;
    end else if (haddr[7:0] == `OFS_CHAN_SEL) begin
      rdValue = {5'h00, chanSelQ};
    end else if (haddr[7:0] == `OFS_IRQ_STAT) begin
      rdValue = {7'h00, irqStatQ};
    end else if (haddr[7:0] == `OFS_IRQ_MASK) begin
      rdValue = {7'h00, irqMaskQ};
    end else begin
      rdValue = 8'h00;
    end
  end

  // Comparator output crosses from the analogue side
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpMetaQ <= 1'b0;
      cmpSyncQ <= 1'b0;
    end else begin
      cmpMetaQ <= cmpOut;
      cmpSyncQ <= cmpMetaQ;
    end
  end

  // Bus slave: writes and result reads take one wait cycle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataPhaseQ <= 1'b0;
      writeQ     <= 1'b0;
      addrQ      <= 8'h00;
      waitDoneQ  <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (dataPhaseQ & ~waitDoneQ) begin
        waitDoneQ <= 1'b1;
        hreadyout <= 1'b1;
        if (!writeQ) begin
          if (addrQ == `OFS_RES_WIDE) begin
            hrdata <= {16'h0000, resultWideQ};
          end else begin
            hrdata <= {24'h000000, resultHighQ};
          end
        end
      end else if (addrPhase) begin
        addrQ  <= haddr[7:0];
        writeQ <= hwrite;
        if (hwrite) begin
          dataPhaseQ <= 1'b1;
          waitDoneQ  <= 1'b0;
          hreadyout  <= 1'b0;
        end else if ((haddr[7:0] == `OFS_RES_WIDE) || (haddr[7:0] == `OFS_RES_HIGH)) begin
          dataPhaseQ <= 1'b1;
          waitDoneQ  <= 1'b0;
          hreadyout  <= 1'b0;
        end else begin
          dataPhaseQ <= 1'b0;
          hrdata     <= {24'h000000, rdValue};
          hreadyout  <= 1'b1;
        end
      end else begin
        dataPhaseQ <= 1'b0;
        hreadyout  <= 1'b1;
      end
    end
  end

  // Converter mode: whole-byte writes plus masked set and clear of any bits
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeQ <= `MODE_RESET;
    end else if (wrNow) begin
      if (addrQ == `OFS_MODE) begin
        modeQ <= hwdata[7:0];
      end else if (addrQ == `OFS_MODE_SET) begin
        modeQ <= modeQ | hwdata[7:0];
      end else if (addrQ == `OFS_MODE_CLR) begin
        modeQ <= modeQ & ~hwdata[7:0];
      end
    end
  end

  // Pin configuration: one bit per shared pin, one means analogue
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinCfgQ <= `PIN_CFG_RESET;
    end else if (wrNow) begin
      if (addrQ == `OFS_PIN_CFG) begin
        pinCfgQ <= hwdata[7:0];
      end
    end
  end

  // Channel selection for the sample-and-hold input
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chanSelQ <= `CHAN_RESET;
    end else if (wrNow) begin
      if (addrQ == `OFS_CHAN_SEL) begin
        chanSelQ <= hwdata[2:0];
      end
    end
  end

  // Interrupt mask
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMaskQ <= 1'b0;
    end else if (wrNow) begin
      if (addrQ == `OFS_IRQ_MASK) begin
        irqMaskQ <= hwdata[0];
      end
    end
  end

  // Conversion sequencer
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ    <= ST_IDLE;
      approxQ   <= 10'h000;
      bitMaskQ  <= 10'h000;
      phaseCntQ <= 8'h00;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          approxQ  <= 10'h000;
          bitMaskQ <= 10'h000;
          if (convRun) begin
            stateQ    <= ST_SAMPLE;
            phaseCntQ <= sampleLen;
          end
        end
        ST_SAMPLE: begin
          if (!convRun) begin
            stateQ <= ST_IDLE;
          end else if (phaseEnd) begin
            stateQ    <= ST_CONVERT;
            approxQ   <= 10'h200;
            bitMaskQ  <= 10'h200;
            phaseCntQ <= bitLen;
          end else begin
            phaseCntQ <= phaseCntQ - 8'h01;
          end
        end
        ST_CONVERT: begin
          if (!convRun) begin
            stateQ <= ST_IDLE;
          end else if (phaseEnd) begin
            approxQ  <= decided | (bitMaskQ >> 1);
            bitMaskQ <= bitMaskQ >> 1;
            if (bitMaskQ[0]) begin
              stateQ    <= ST_SAMPLE;
              phaseCntQ <= sampleLen;
            end else begin
              phaseCntQ <= bitLen;
            end
          end else begin
            phaseCntQ <= phaseCntQ - 8'h01;
          end
        end
        default: begin
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  // Results load at the same edge that sets the completion flag
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resultWideQ <= 16'h0000;
      resultHighQ <= 8'h00;
    end else begin
      if (doneEvent) begin
        resultWideQ <= {decided, 6'h00};
        resultHighQ <= decided[9:2];
      end
    end
  end

  // Sticky completion flag; a new completion beats a clear in the same cycle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatQ    <= 1'b0;
      convDoneIrq <= 1'b0;
    end else begin
      irqStatQ    <= irqNext;
      convDoneIrq <= irqNext & irqMaskQ;
    end
  end

  // Analogue-side outputs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dacCode         <= 10'h000;
      sampleHold      <= 1'b0;
      analogueChannel <= 3'h0;
    end else begin
      dacCode         <= approxQ;
      sampleHold      <= (stateQ == ST_CONVERT);
      analogueChannel <= chanSelQ;
    end
  end

  // Comparator enable; results right after enabling it are not trustworthy
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      comparatorOn <= 1'b0;
    end else begin
      comparatorOn <= modeQ[`MODE_CMP_BIT];
    end
  end

  // Pin-side outputs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      analogueInputEn <= 8'h00;
      digitalPortEn   <= 8'hFF;
    end else begin
      analogueInputEn <= pinCfgQ;
      digitalPortEn   <= ~pinCfgQ;
    end
  end

endmodule // sar_adc_control
`default_nettype wire

// ---- verification/sar_adc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_checker (
  // Bus side
  input wire logic        core_clk, rst_b, hsel, hwrite, hreadyout,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  // Converter side
  input wire logic        sampleHold, convDoneIrq,
  input wire logic [9:0]  dacCode,
  input wire logic [7:0]  analogueInputEn, digitalPortEn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence taken; hsel && htrans[1] && hreadyout; endsequence
  sequence resRd; taken ##0 !hwrite && (haddr[7:0] == `OFS_RES_WIDE || haddr[7:0] == `OFS_RES_HIGH); endsequence
  sequence modeRd; taken ##0 !hwrite && haddr[7:0] == `OFS_MODE; endsequence
  sequence waitOne; !hreadyout ##1 hreadyout; endsequence
  chk_res_wait: assert property (resRd |=> waitOne)
    else $error("no result wait");
  chk_mode_nowait: assert property (modeRd |=> hreadyout)
    else $error("mode read stalled");
  chk_write_wait: assert property ((taken ##0 hwrite) |=> waitOne)
    else $error("no write wait");
  chk_pin_split: assert property (digitalPortEn == ~analogueInputEn)
    else $error("pin split");
  chk_msb_trial: assert property ($rose(sampleHold) |-> ##[0:2] dacCode == 10'h200)
    else $error("no msb trial");
  chk_trial_hold: assert property ($changed(dacCode) && sampleHold |=> ($stable(dacCode) || !sampleHold) [*3])
    else $error("trial short");
  chk_sample_len: assert property ($fell(sampleHold) |-> !sampleHold [*4])
    else $error("sample short");
  chk_irq_end: assert property ($rose(convDoneIrq) |-> $past(sampleHold))
    else $error("irq not at end");
endmodule // sar_adc_checker
bind sar_adc_control sar_adc_checker sar_adc_checker_i (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
  .hwrite(hwrite), .hreadyout(hreadyout), .haddr(haddr), .htrans(htrans), .sampleHold(sampleHold),
  .convDoneIrq(convDoneIrq), .dacCode(dacCode), .analogueInputEn(analogueInputEn), .digitalPortEn(digitalPortEn));
`default_nettype wire

// ---- verification/analogue_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module analogue_source #(parameter int SETTLE_NS = 3) (
  // Converter side
  input wire logic       sampleHold,
  input wire logic [2:0] analogueChannel,
  input wire logic [7:0] analogueInputEn,
  input wire logic [9:0] dacCode,
  // Pin levels, ten bits per pin
  input wire logic [79:0] levels,
  output logic            cmpOut
);
  logic [9:0] held = 10'h000;
  // A digital pin presents no voltage to the selector
  always @(posedge sampleHold)
    held <= analogueInputEn[analogueChannel] ? levels[analogueChannel*10 +: 10] : 10'h000;
  assign #(SETTLE_NS) cmpOut = held >= dacCode;
endmodule // analogue_source
`default_nettype wire

// ---- verification/sar_adc_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_control_tb_top;
  logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
  logic hreadyout, hresp, cmpOut, sampleHold, comparatorOn, convDoneIrq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] ch, analogueChannel;
  logic [9:0] dacCode, lvl;
  logic [7:0] pin, analogueInputEn, digitalPortEn;
  logic [79:0] levels = 80'h0;
  logic [31:0] expQ[$];
  int fail_count = 0;
  int checks = 0;
  int k;
  always #4 core_clk = ~core_clk;
  sar_adc_control sar_adc_control_i (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmpOut(cmpOut), .dacCode(dacCode), .sampleHold(sampleHold),
    .analogueChannel(analogueChannel), .comparatorOn(comparatorOn), .analogueInputEn(analogueInputEn),
    .digitalPortEn(digitalPortEn), .convDoneIrq(convDoneIrq));
  analogue_source #(.SETTLE_NS(20)) analogue_source_i (.sampleHold(sampleHold),
    .analogueChannel(analogueChannel), .analogueInputEn(analogueInputEn), .dacCode(dacCode),
    .levels(levels), .cmpOut(cmpOut));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One single transfer; a read notes its expected data
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    if (!w) expQ.push_back(d);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  always @(posedge core_clk) begin
    if (rdPend && hreadyout) check(hrdata, expQ.pop_front());
    if (hreadyout) rdPend <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    pin = $urandom(32'hB810);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    check(digitalPortEn, 8'hFF);
    bus(`OFS_MODE, 1'b0, 32'h0);
    bus(8'h40, 1'b0, 32'h0);
    bus(`OFS_PIN_CFG, 1'b1, {24'h0, pin});
    bus(`OFS_PIN_CFG, 1'b0, {24'h0, pin});
    check(analogueInputEn, pin);
    check(digitalPortEn, {24'h0, ~pin});
    bus(`OFS_MODE_SET, 1'b1, 32'h1);
    bus(`OFS_MODE, 1'b0, 32'h1);
    check(comparatorOn, 1'b1);
    bus(`OFS_MODE_CLR, 1'b1, 32'h1);
    bus(`OFS_MODE, 1'b0, 32'h0);
    check(comparatorOn, 1'b0);
    bus(`OFS_PIN_CFG, 1'b1, 32'hFF);
    bus(`OFS_IRQ_MASK, 1'b1, 32'h1);
    for (int s = 0; s < 6; s++) begin
      ch = $urandom;
      lvl = $urandom;
      levels[ch*10 +: 10] <= lvl;
      bus(`OFS_CHAN_SEL, 1'b1, {29'h0, ch});
      bus(`OFS_MODE, 1'b1, {24'h0, 2'b00, s[2:0], 3'h1});
      repeat (125) @(posedge core_clk);
      bus(`OFS_MODE, 1'b1, {24'h0, 2'b10, s[2:0], 3'h1});
      k = 0;
      while (convDoneIrq !== 1'b1 && k < 2000) begin
        @(posedge core_clk);
        k++;
      end
      check(analogueChannel, ch);
      bus(`OFS_RES_WIDE, 1'b0, {16'h0, lvl, 6'h0});
      bus(`OFS_RES_HIGH, 1'b0, {24'h0, lvl[9:2]});
      bus(`OFS_IRQ_STAT, 1'b0, 32'h1);
      bus(`OFS_MODE, 1'b1, 32'h0);
      bus(`OFS_IRQ_STAT, 1'b1, 32'h1);
      @(posedge core_clk);
      check(convDoneIrq, 1'b0);
    end
    repeat (2) @(posedge core_clk);
    report_and_stop;
  end
endmodule // sar_adc_control_tb_top
`default_nettype wire
